// ---- ssf_defs.vh ----
// How it works
// - lock captures first source, then drops others
// - relearn falling edge clears captured source
// - 802.1X needs global and port enable
// - EAPOL is type 888E or that address
// - EAPOL to host under 802.1X unless another check drops it; normal needs authorization
// - tagged frame dropped if port not member
// - freeze stops learning, updates and aging
// - static table entries never overwritten
// - filter enable drops table destination matches
// - filter enable drops table source matches
// - eight entries drop on destination or source
// - paired entries drop on either flagged match
// - security entry overrides conflicting table entry
`ifndef SSF_DEFS_VH
`define SSF_DEFS_VH
// ============================================================
// register byte offsets
`define SSF_OFS_GLOBAL 8'h00
`define SSF_OFS_LOCK 8'h04
`define SSF_OFS_VLAN 8'h08
`define SSF_OFS_PORT0 8'h0C
`define SSF_OFS_PORT1 8'h10
`define SSF_OFS_PORT2 8'h14
`define SSF_OFS_STATUS 8'h18
`define SSF_OFS_SEC_BASE 8'h40
`define SSF_OFS_SEC_LAST 8'h7C
// ============================================================
// field positions
`define SSF_BIT_FILTER_EN 4
`define SSF_BIT_FREEZE 5
`define SSF_BIT_DOT1X_GLB 21
`define SSF_LOCK_EN_HI 31
`define SSF_LOCK_EN_LO 29
`define SSF_RELEARN_HI 28
`define SSF_RELEARN_LO 26
`define SSF_VLAN_CHK_HI 10
`define SSF_VLAN_CHK_LO 8
`define SSF_BIT_DOT1X_PORT 11
`define SSF_BIT_AUTH 12
`define SSF_BIT_SEC_DEST 16
`define SSF_BIT_SEC_SRC 17
`define SSF_BIT_SEC_PAIR 18
// ============================================================
// reset values and constants
`define SSF_RST_GLOBAL 32'h0000_0000
`define SSF_EAPOL_TYPE 16'h888E
`define SSF_EAPOL_DEST 48'h0180C2000003
`endif

// ---- ssf_port_lock.v ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// single-source lock for one port: holds the captured source
module ssf_port_lock (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // control
    input wire lock_en,
    input wire relearn,
    // frame seen on this port
    input wire frm_hit,
    input wire [47:0] frm_src,
    // state
    output reg locked_ff,
    output reg [47:0] addr_ff,
    output wire src_bad
);
    reg relearn_ff; // previous relearn level, for edge detect

    // a captured port refuses every other source while lock_en is set
    assign src_bad = lock_en & locked_ff & (frm_src != addr_ff);

    // ========================================================
    // capture and clear
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            relearn_ff <= 1'b0;
            locked_ff <= 1'b0;
            addr_ff <= 48'h0000_0000_0000;
        end else begin
            relearn_ff <= relearn;
            if (relearn_ff & ~relearn) begin
                // one-to-zero edge forgets the source
                locked_ff <= 1'b0;
            end else if (lock_en & ~locked_ff & frm_hit) begin
                // first frame after enable is the one kept
                locked_ff <= 1'b1;
                addr_ff <= frm_src;
            end
        end
    end
endmodule // ssf_port_lock
`default_nettype wire

// ---- ssf_filter.v ----
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_defs.vh"
// ============================================================
// ingress security filter of a three-port switch core
module ssf_filter #(
    parameter NPORT = 3,
    parameter NSEC = 8
) (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // frame from forwarding engine, one-cycle strobe
    input wire frm_valid,
    input wire [1:0] frm_port,
    input wire [47:0] frm_dest,
    input wire [47:0] frm_src,
    input wire [15:0] frm_type,
    input wire frm_tagged,
    input wire frm_vlan_member,
    input wire tbl_dest_drop,
    input wire tbl_src_drop,
    // frame decision, one cycle after the strobe
    output reg dec_valid_ff,
    output reg dec_drop_ff,
    output reg dec_to_host_ff,
    output reg [1:0] dec_port_ff,
    // host transmit check
    input wire tx_valid,
    input wire [1:0] tx_port,
    input wire tx_eapol,
    output reg tx_allow_ff,
    output reg tx_done_ff,
    // address table learning
    input wire lrn_req,
    input wire [1:0] lrn_port,
    input wire lrn_static,
    output reg lrn_grant_ff,
    output reg lrn_done_ff,
    output reg age_enable_ff
);
    // control registers
    reg [31:0] glb_ff; // global switch control
    reg [31:0] lock_ff; // learning lock control
    reg [31:0] vlan_ff; // port vlan control
    reg [31:0] pmisc_ff [0:2]; // per port misc control
    reg [47:0] sec_addr_ff [0:7]; // security address entries
    reg [2:0] sec_flag_ff [0:7]; // dest, src, pair flags
    reg [2:0] drop_seen_ff; // sticky per port drop indication
    // derived
    wire [2:0] locked;
    wire [2:0] src_bad;
    wire [2:0] frm_hit;
    wire [2:0] lock_hold; // captured and still enabled: no learning
    wire freeze;
    wire filter_en;
    reg [2:0] dot1x_act;
    reg [2:0] auth;
    reg is_eapol;
    reg sec_dest_any;
    reg sec_src_any;
    reg sec_drop;
    reg tbl_drop;
    reg vlan_drop;
    reg auth_drop;
    reg nxt_drop;
    reg nxt_host;
    reg [31:0] rd_mux;
    reg rd_err;
    integer i; // loop index of the combinational decode
    integer j; // loop index of the decision register
    integer m; // loop index of the register reset
    genvar g;

    assign freeze = glb_ff[`SSF_BIT_FREEZE];
    // learning stops only once the port has kept its source
    assign lock_hold = locked & lock_ff[`SSF_LOCK_EN_HI:`SSF_LOCK_EN_LO];
    assign filter_en = glb_ff[`SSF_BIT_FILTER_EN];

    // ========================================================
    // helper functions
    // security entry hit for one address and flag
    function sec_hit;
        input [47:0] a;
        input [47:0] e;
        input f;
        begin
            sec_hit = f & (a == e);
        end
    endfunction

    // per port enable bit from a control word
    function port_bit;
        input [31:0] w;
        input [1:0] p;
        input integer lo;
        begin
            port_bit = (p < 2'd3) ? w[lo + p] : 1'b0;
        end
    endfunction

    // ========================================================
    // per port single-source lock units
    generate
        for (g = 0; g < NPORT; g = g + 1) begin : g_lock
            assign frm_hit[g] = frm_valid & (frm_port == g);
            ssf_port_lock u_lock (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .lock_en(lock_ff[`SSF_LOCK_EN_LO + g]),
                .relearn(lock_ff[`SSF_RELEARN_LO + g]),
                .frm_hit(frm_hit[g]),
                .frm_src(frm_src),
                .locked_ff(locked[g]),
                .addr_ff(),
                .src_bad(src_bad[g])
            );
        end
    endgenerate

    // ========================================================
    // frame classification and drop combination
    always @* begin
        for (i = 0; i < 3; i = i + 1) begin
            // active only with both enables set
            dot1x_act[i] = glb_ff[`SSF_BIT_DOT1X_GLB] &
                pmisc_ff[i][`SSF_BIT_DOT1X_PORT];
            auth[i] = pmisc_ff[i][`SSF_BIT_AUTH];
        end
        // only type and destination are examined
        is_eapol = (frm_type == `SSF_EAPOL_TYPE) |
            (frm_dest == `SSF_EAPOL_DEST);
        sec_dest_any = 1'b0;
        sec_src_any = 1'b0;
        sec_drop = 1'b0;
        for (i = 0; i < NSEC; i = i + 1) begin
            // an entry with any flag set owns its address
            sec_dest_any = sec_dest_any |
                sec_hit(frm_dest, sec_addr_ff[i], |sec_flag_ff[i]);
            sec_src_any = sec_src_any |
                sec_hit(frm_src, sec_addr_ff[i], |sec_flag_ff[i]);
            // paired or single, each entry drops on its own flag
            sec_drop = sec_drop |
                sec_hit(frm_dest, sec_addr_ff[i], sec_flag_ff[i][0]) |
                sec_hit(frm_src, sec_addr_ff[i], sec_flag_ff[i][1]);
        end
        // table flags lose to a security entry on the same address
        tbl_drop = filter_en &
            ((tbl_dest_drop & ~sec_dest_any) |
             (tbl_src_drop & ~sec_src_any));
        vlan_drop = frm_tagged & ~frm_vlan_member &
            port_bit(vlan_ff, frm_port, `SSF_VLAN_CHK_LO);
        nxt_host = is_eapol & port_bit({29'h0, dot1x_act}, frm_port, 0);
        // redirected eapol bypasses the authorization drop
        auth_drop = ~nxt_host & ~port_bit({29'h0, auth}, frm_port, 0) &
            port_bit({29'h0, dot1x_act}, frm_port, 0);
        // any single condition discards the frame
        nxt_drop = sec_drop | tbl_drop | vlan_drop | auth_drop |
            port_bit({29'h0, src_bad}, frm_port, 0);
    end

    // ========================================================
    // registered frame decision
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid_ff <= 1'b0;
            dec_drop_ff <= 1'b0;
            dec_to_host_ff <= 1'b0;
            dec_port_ff <= 2'h0;
            drop_seen_ff <= 3'h0;
        end else begin
            dec_valid_ff <= frm_valid;
            if (frm_valid) begin
                // redirection to host wins only if nothing drops
                dec_drop_ff <= nxt_drop;
                dec_to_host_ff <= nxt_host & ~nxt_drop;
                dec_port_ff <= frm_port;
            end
            // set wins over a clear in the same cycle
            for (j = 0; j < 3; j = j + 1) begin
                if (frm_valid & nxt_drop & (frm_port == j)) begin
                    drop_seen_ff[j] <= 1'b1;
                end else if (psel & penable & pwrite &
                        (paddr == `SSF_OFS_STATUS) & pwdata[8 + j]) begin
                    drop_seen_ff[j] <= 1'b0;
                end
            end
        end
    end

    // ========================================================
    // host transmit check: eapol may go anywhere
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_allow_ff <= 1'b0;
            tx_done_ff <= 1'b0;
        end else begin
            tx_done_ff <= tx_valid;
            if (tx_valid) begin
                tx_allow_ff <= tx_eapol |
                    ~port_bit({29'h0, dot1x_act}, tx_port, 0) |
                    port_bit({29'h0, auth}, tx_port, 0);
            end
        end
    end

    // ========================================================
    // learning and aging gate toward the address table
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lrn_grant_ff <= 1'b0;
            lrn_done_ff <= 1'b0;
            age_enable_ff <= 1'b1;
        end else begin
            lrn_done_ff <= lrn_req;
            age_enable_ff <= ~freeze;
            if (lrn_req) begin
                // frozen table, static entry or locked port: no write
                lrn_grant_ff <= ~freeze & ~lrn_static &
                    ~port_bit({29'h0, lock_hold}, lrn_port, 0);
            end
        end
    end

    // ========================================================
    // apb read mux; unmapped addresses flag an error
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            rd_err = 1'b1;
        end else if (paddr >= `SSF_OFS_SEC_BASE &&
                paddr <= `SSF_OFS_SEC_LAST) begin
            // even word: address low, odd word: address high and flags
            if (paddr[2]) begin
                rd_mux = {13'h0000, sec_flag_ff[paddr[5:3]],
                    sec_addr_ff[paddr[5:3]][47:32]};
            end else begin
                rd_mux = sec_addr_ff[paddr[5:3]][31:0];
            end
        end else begin
            case (paddr)
                `SSF_OFS_GLOBAL: rd_mux = glb_ff;
                `SSF_OFS_LOCK: rd_mux = lock_ff;
                `SSF_OFS_VLAN: rd_mux = vlan_ff;
                `SSF_OFS_PORT0: rd_mux = pmisc_ff[0];
                `SSF_OFS_PORT1: rd_mux = pmisc_ff[1];
                `SSF_OFS_PORT2: rd_mux = pmisc_ff[2];
                `SSF_OFS_STATUS: rd_mux = {21'h0, drop_seen_ff, 5'h0, locked};
                default: rd_err = 1'b1;
            endcase
        end
    end

    // ========================================================
    // apb slave: zero wait states, write lands at access edge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            glb_ff <= `SSF_RST_GLOBAL;
            lock_ff <= 32'h0000_0000;
            vlan_ff <= 32'h0000_0000;
            for (m = 0; m < 3; m = m + 1) begin
                pmisc_ff[m] <= 32'h0000_0000;
            end
            for (m = 0; m < NSEC; m = m + 1) begin
                sec_addr_ff[m] <= 48'h0000_0000_0000;
                sec_flag_ff[m] <= 3'h0;
            end
        end else begin
            // ready and answer prepared in the setup cycle
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & rd_err;
            if (psel & ~penable & ~pwrite) begin
                prdata <= rd_mux;
            end
            if (psel & penable & pwrite & ~rd_err) begin
                if (paddr >= `SSF_OFS_SEC_BASE) begin
                    if (paddr[2]) begin
                        sec_addr_ff[paddr[5:3]][47:32] <= pwdata[15:0];
                        sec_flag_ff[paddr[5:3]] <= pwdata[18:16];
                    end else begin
                        sec_addr_ff[paddr[5:3]][31:0] <= pwdata;
                    end
                end else begin
                    case (paddr)
                        `SSF_OFS_GLOBAL: glb_ff <= pwdata;
                        `SSF_OFS_LOCK: lock_ff <= pwdata;
                        `SSF_OFS_VLAN: vlan_ff <= pwdata;
                        `SSF_OFS_PORT0: pmisc_ff[0] <= pwdata;
                        `SSF_OFS_PORT1: pmisc_ff[1] <= pwdata;
                        `SSF_OFS_PORT2: pmisc_ff[2] <= pwdata;
                        default: ; // status is handled above
                    endcase
                end
            end
        end
    end
endmodule // ssf_filter
`default_nettype wire

// ---- ssf_filter_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checks of the filter: latencies and decision relations
module ssf_filter_checker (
    input wire logic clk_sys, rst_n, psel, penable, pready, frm_valid,
    input wire logic dec_valid_ff, dec_drop_ff, dec_to_host_ff,
    input wire logic [1:0] frm_port, dec_port_ff,
    input wire logic [47:0] frm_dest,
    input wire logic [15:0] frm_type,
    input wire logic tx_valid, tx_done_ff, lrn_req, lrn_static,
    input wire logic lrn_done_ff, lrn_grant_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_dec_one_later: assert property (frm_valid |=> dec_valid_ff)
        else $error("no decision one cycle after frame");
    a_dec_no_spurious: assert property (!frm_valid |=> !dec_valid_ff)
        else $error("decision without frame");
    a_port_echoed: assert property (frm_valid |=> dec_port_ff == $past(frm_port))
        else $error("receiving port not reported");
    // a type one off 888E must not count as control traffic
    a_plain_not_host: assert property (frm_valid && frm_type != 16'h888E
        && frm_dest != 48'h0180C2000003 |=> !dec_to_host_ff)
        else $error("ordinary frame sent to host");
    a_host_not_dropped: assert property (dec_valid_ff && dec_to_host_ff |-> !dec_drop_ff)
        else $error("frame both dropped and redirected");
    a_tx_answer: assert property (tx_done_ff == $past(tx_valid))
        else $error("transmit query not answered once");
    a_static_kept: assert property (lrn_req && lrn_static |=> lrn_done_ff && !lrn_grant_ff)
        else $error("static entry granted to learning");
    a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one access cycle");
    c_drop: cover property (dec_valid_ff && dec_drop_ff);
    c_host: cover property (dec_valid_ff && dec_to_host_ff);
    c_grant: cover property (lrn_done_ff && lrn_grant_ff);
endmodule // ssf_filter_checker
bind ssf_filter ssf_filter_checker chk_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .frm_valid(frm_valid), .dec_valid_ff(dec_valid_ff),
    .dec_drop_ff(dec_drop_ff), .dec_to_host_ff(dec_to_host_ff),
    .frm_port(frm_port), .dec_port_ff(dec_port_ff), .frm_dest(frm_dest),
    .frm_type(frm_type), .tx_valid(tx_valid), .tx_done_ff(tx_done_ff),
    .lrn_req(lrn_req), .lrn_static(lrn_static),
    .lrn_done_ff(lrn_done_ff), .lrn_grant_ff(lrn_grant_ff)
);
`default_nettype wire

// ---- ssf_fwd_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// forwarding engine: presents headers and its own table lookup
module ssf_fwd_model (
    input wire logic clk_sys, h_go, h_tag, h_mem, h_tbl_dd, h_tbl_sd,
    input wire logic [1:0] h_port,
    input wire logic [47:0] h_dest, h_src, h_tbl_addr,
    input wire logic [15:0] h_type,
    output logic frm_valid, frm_tagged, frm_vlan_member,
    output logic tbl_dest_drop, tbl_src_drop,
    output logic [1:0] frm_port,
    output logic [47:0] frm_dest, frm_src,
    output logic [15:0] frm_type
);
    initial {frm_valid, frm_tagged, frm_vlan_member, tbl_dest_drop,
        tbl_src_drop, frm_port, frm_dest, frm_src, frm_type} = '0;
    // header lines flip between frames so stale values never pass
    always @(posedge clk_sys) begin
        frm_valid <= h_go;
        frm_port <= h_go ? h_port : ~frm_port;
        frm_dest <= h_go ? h_dest : ~frm_dest;
        frm_src <= h_go ? h_src : ~frm_src;
        frm_type <= h_go ? h_type : ~frm_type;
        frm_tagged <= h_go ? h_tag : ~frm_tagged;
        frm_vlan_member <= h_go ? h_mem : ~frm_vlan_member;
        tbl_dest_drop <= h_go ? h_tbl_dd && h_dest == h_tbl_addr : ~tbl_dest_drop;
        tbl_src_drop <= h_go ? h_tbl_sd && h_src == h_tbl_addr : ~tbl_src_drop;
    end
endmodule // ssf_fwd_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ============================================================
    // signals, named as the ports they drive
    logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, frm_valid, frm_tagged, frm_vlan_member;
    logic tbl_dest_drop, tbl_src_drop, dec_valid_ff, dec_drop_ff;
    logic dec_to_host_ff, tx_allow_ff, tx_done_ff, lrn_grant_ff;
    logic lrn_done_ff, age_enable_ff, tx_valid = 0, tx_eapol = 0;
    logic lrn_req = 0, lrn_static = 0, h_go = 0, h_tag = 0, h_mem = 0;
    logic h_tbl_dd = 0, h_tbl_sd = 0;
    logic [1:0] frm_port, dec_port_ff, tx_port = 0, lrn_port = 0, h_port = 0;
    logic [47:0] frm_dest, frm_src, h_dest = 0, h_src = 0, h_tbl_addr = 0;
    logic [15:0] frm_type, h_type = 0;
    int num_errors = 0, samples_checked = 0, k;
    // reference state of the bench
    logic [31:0] glb = 0, lk = 0, vl = 0, pm [3] = '{default: 32'h0};
    logic [47:0] sa [8], cap [3], a, b;
    logic [2:0] sf [8] = '{default: 3'h0};
    logic [2:0] seen = 3'h0;
    logic capv [3] = '{default: 1'b0};
    always #4 clk_sys = ~clk_sys;
    ssf_filter dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid),
        .frm_port(frm_port), .frm_dest(frm_dest), .frm_src(frm_src),
        .frm_type(frm_type), .frm_tagged(frm_tagged),
        .frm_vlan_member(frm_vlan_member), .tbl_dest_drop(tbl_dest_drop),
        .tbl_src_drop(tbl_src_drop), .dec_valid_ff(dec_valid_ff),
        .dec_drop_ff(dec_drop_ff), .dec_to_host_ff(dec_to_host_ff),
        .dec_port_ff(dec_port_ff), .tx_valid(tx_valid), .tx_port(tx_port),
        .tx_eapol(tx_eapol), .tx_allow_ff(tx_allow_ff),
        .tx_done_ff(tx_done_ff), .lrn_req(lrn_req), .lrn_port(lrn_port),
        .lrn_static(lrn_static), .lrn_grant_ff(lrn_grant_ff),
        .lrn_done_ff(lrn_done_ff), .age_enable_ff(age_enable_ff)
    );
    ssf_fwd_model fwd_u (
        .clk_sys(clk_sys), .h_go(h_go), .h_tag(h_tag), .h_mem(h_mem),
        .h_tbl_dd(h_tbl_dd), .h_tbl_sd(h_tbl_sd), .h_port(h_port),
        .h_dest(h_dest), .h_src(h_src), .h_tbl_addr(h_tbl_addr),
        .h_type(h_type), .frm_valid(frm_valid), .frm_tagged(frm_tagged),
        .frm_vlan_member(frm_vlan_member), .tbl_dest_drop(tbl_dest_drop),
        .tbl_src_drop(tbl_src_drop), .frm_port(frm_port),
        .frm_dest(frm_dest), .frm_src(frm_src), .frm_type(frm_type)
    );
    task automatic chk(input string n, input logic [47:0] e, g);
        samples_checked++;
        if (e !== g) begin
            num_errors++;
            $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
        end
    endtask
    // one apb transfer; waits for pready, bounded only by the watchdog
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] d, output logic [31:0] r, output logic er);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
        @(posedge clk_sys);
        penable <= 1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ad, d, r, e);
        for (int i = 0; i < 3; i++) if (lk[26+i] && !d[26+i] && ad == 8'h04) capv[i] = 0;
        case (ad)
            8'h00: glb = d;
            8'h04: lk = d;
            8'h08: vl = d;
            8'h0C, 8'h10, 8'h14: pm[(ad - 8'h0C) >> 2] = d;
            8'h18: seen = seen & ~d[10:8];
            default: if (ad[2]) {sf[ad[5:3]], sa[ad[5:3]][47:32]} = d[18:0];
                else sa[ad[5:3]][31:0] = d;
        endcase
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, ad, 32'h0, r, e);
        chk("pslverr", xe, e);
        if (!xe) chk("prdata", x, r);
    endtask
    // one frame through the engine, compared with the reference
    task automatic frame(input logic [1:0] p, input logic [47:0] de, s,
        input logic [15:0] ty, input logic t, m);
        logic drop = 0, eap, act, ovd = 0, ovs = 0;
        @(posedge clk_sys);
        {h_go, h_port, h_dest, h_src, h_type, h_tag, h_mem} <= {1'b1, p, de, s, ty, t, m};
        @(posedge clk_sys);
        h_go <= 0;
        @(posedge clk_sys);
        #1;
        eap = ty == 16'h888E || de == 48'h0180C2000003;
        act = glb[21] && pm[p][11];
        for (int i = 0; i < 8; i++) begin
            if (sf[i] != 0 && sa[i] == de) ovd = 1;
            if (sf[i] != 0 && sa[i] == s) ovs = 1;
            if ((sf[i][0] && sa[i] == de) || (sf[i][1] && sa[i] == s)) drop = 1;
        end
        if (glb[4] && h_tbl_dd && de == h_tbl_addr && !ovd) drop = 1;
        if (glb[4] && h_tbl_sd && s == h_tbl_addr && !ovs) drop = 1;
        if (vl[8+p] && t && !m) drop = 1;
        if (act && !pm[p][12] && !eap) drop = 1;
        if (lk[29+p] && capv[p] && cap[p] != s) drop = 1;
        if (drop) seen[p] = 1'b1;
        if (lk[29+p] && !capv[p]) {capv[p], cap[p]} = {1'b1, s};
        chk("dec_valid", 1, dec_valid_ff);
        chk("dec_drop", drop, dec_drop_ff);
        chk("dec_to_host", eap && act && !drop, dec_to_host_ff);
        chk("dec_port", p, dec_port_ff);
    endtask
    task automatic txq(input logic [1:0] p, input logic e);
        @(posedge clk_sys);
        {tx_valid, tx_port, tx_eapol} <= {1'b1, p, e};
        @(posedge clk_sys);
        tx_valid <= 0;
        #1 chk("tx_allow", e || !(glb[21] && pm[p][11]) || pm[p][12], tx_allow_ff);
    endtask
    task automatic lrn(input logic [1:0] p, input logic s);
        @(posedge clk_sys);
        {lrn_req, lrn_port, lrn_static} <= {1'b1, p, s};
        @(posedge clk_sys);
        lrn_req <= 0;
        #1 chk("lrn_grant", !glb[5] && !s && !(lk[29+p] && capv[p]), lrn_grant_ff);
        chk("age_enable", !glb[5], age_enable_ff);
    endtask
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        print_verdict;
    end
    // ============================================================
    // main sequence
    initial begin
        k = $urandom(32'h1f3e7409);
        b = {16'($urandom), $urandom};
        repeat (2) @(posedge clk_sys);
        rst_n <= 1;
        rd(8'h00, 32'h0, 1'b0);
        rd(8'h1C, 32'h0, 1'b1);
        // table flags gated by the global filter bit
        for (k = 0; k < 8; k++) begin
            wr(8'h00, {27'h0, k[0], 4'h0});
            a = {16'($urandom), $urandom};
            {h_tbl_addr, h_tbl_dd, h_tbl_sd} <= {a, k[1], k[2]};
            frame(2'(k % 3), a, b, 16'h0800, 1'b0, 1'b1);
            frame(2'(k % 3), b, a, 16'h0800, 1'b0, 1'b1);
        end
        // 802.1X enables, authorization and vlan check on port 1
        for (k = 0; k < 16; k++) begin
            wr(8'h00, {10'h0, k[0], 21'h0});
            wr(8'h10, {19'h0, k[2], k[1], 11'h0});
            wr(8'h08, {22'h0, k[3], 9'h0});
            frame(2'd1, b, a, 16'h888E, 1'b0, 1'b1);
            frame(2'd1, 48'h0180C2000003, a, 16'h0800, 1'b0, 1'b1);
            frame(2'd1, b, a, 16'h888F, 1'b0, 1'b1);
            frame(2'd1, b, a, 16'h0800, 1'b1, 1'b0);
            txq(2'd1, k[3]);
        end
        // single-source lock on port 0 under frozen learning
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h0000_0020);
        wr(8'h04, 32'h2400_0000);
        frame(2'd0, b, a, 16'h0800, 1'b0, 1'b1);
        frame(2'd0, b, b, 16'h0800, 1'b0, 1'b1);
        frame(2'd0, b, a, 16'h0800, 1'b0, 1'b1);
        wr(8'h04, 32'h2000_0000);
        frame(2'd0, a, b, 16'h0800, 1'b0, 1'b1);
        frame(2'd0, b, a, 16'h0800, 1'b0, 1'b1);
        rd(8'h18, {21'h0, seen, 5'h0, capv[2], capv[1], capv[0]}, 1'b0);
        wr(8'h18, 32'h0000_0700);
        rd(8'h18, {21'h0, seen, 5'h0, capv[2], capv[1], capv[0]}, 1'b0);
        lrn(2'd2, 1'b0);
        wr(8'h00, 32'h0);
        lrn(2'd0, 1'b0);
        lrn(2'd2, 1'b0);
        lrn(2'd2, 1'b1);
        // eight security entries, pairs 4-5 and 6-7 set on both
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0000_0010);
        for (k = 0; k < 8; k++) begin
            a = {16'($urandom), $urandom};
            wr(8'(8'h40 + 8 * k), a[31:0]);
            wr(8'(8'h44 + 8 * k), {13'h0, k[2], k[0], !k[0], a[47:16+16]});
        end
        {h_tbl_addr, h_tbl_dd, h_tbl_sd} <= {sa[0], 1'b1, 1'b1};
        for (k = 0; k < 8; k++) begin
            frame(2'(k % 3), sa[k], b, 16'h0800, 1'b0, 1'b1);
            frame(2'(k % 3), b, sa[k], 16'h0800, 1'b0, 1'b1);
        end
        print_verdict;
    end
endmodule // tb
`default_nettype wire
